/* File: udps_pkg.sv */
/*
  Constants and types of the packet sequencer.
  Assumes a 20 MHz clock and a word-aligned byte-addressed register port.
*/
`default_nettype none
package udps_pkg;
  // Timing
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned MS_NS       = 1000000;
  localparam int unsigned CYC_PER_MS  = MS_NS / CLK_NS;
  localparam int unsigned MAX_SEGS    = 64;
  localparam logic [5:0]  SEG_LAST    = 6'h3f;
  localparam logic [3:0]  CMD_LAST    = 4'hf;

  // Register byte offsets
  localparam logic [10:0] OFS_CTRL    = 11'h000;
  localparam logic [10:0] OFS_STATUS  = 11'h004;
  localparam logic [10:0] OFS_WAIT    = 11'h008;
  localparam logic [10:0] OFS_TMO     = 11'h00c;
  localparam logic [10:0] OFS_GROUPS  = 11'h010;
  localparam logic [4:0]  SEL_MREG    = 5'h01;
  localparam logic [4:0]  SEL_CMD     = 5'h02;
  localparam int unsigned CTRL_START  = 0;
  localparam int unsigned CTRL_STOP   = 1;

  // Reset values
  localparam logic [15:0] WAIT_RST    = 16'h0000;
  localparam logic [15:0] TMO_RST     = 16'h0032;
  localparam logic [19:0] GROUPS_RST  = 20'h00000;

  typedef enum logic [1:0] {
    CLS_MSG = 2'h0, CLS_ADDR = 2'h1, CLS_LEN = 2'h2, CLS_CKS = 2'h3
  } udps_cls_t;
  typedef enum logic [1:0] {
    FMT_NULL = 2'h0, FMT_HEX = 2'h1, FMT_ASCII = 2'h2, FMT_CODE = 2'h3
  } udps_fmt_t;
  typedef enum logic [1:0] {
    FN_READ = 2'h0, FN_WRITE = 2'h1, FN_IGNORE = 2'h2, FN_RSV = 2'h3
  } udps_fn_t;
  typedef enum logic [1:0] {
    CK_SUM16 = 2'h0, CK_XOR8 = 2'h1, CK_SUM8 = 2'h2, CK_RSV = 2'h3
  } udps_ck_t;
  typedef enum logic [1:0] {
    TY_NONE = 2'h0, TY_SEND = 2'h1, TY_RECV = 2'h2, TY_BOTH = 2'h3
  } udps_ty_t;
  // Success: next/goto/end; failure: next/goto/abort
  typedef enum logic [1:0] {
    ACT_NEXT = 2'h0, ACT_GOTO = 2'h1, ACT_STOP = 2'h2, ACT_RSV = 2'h3
  } udps_act_t;

  typedef struct packed {
    logic [11:0] rsv;
    udps_ck_t    ckcls;
    logic        rev;
    logic        two;
    udps_fn_t    func;
    logic        vsel;
    udps_fmt_t   fmt;
    udps_cls_t   cls;
    logic        last;
    logic [7:0]  val;
  } udps_seg_t;

  typedef struct packed {
    logic [5:0]  rsv;
    logic [3:0]  repeat_n;
    logic [3:0]  retry_n;
    logic [3:0]  ftgt;
    udps_act_t   fact;
    logic [3:0]  stgt;
    udps_act_t   sact;
    logic [1:0]  rxp;
    logic [1:0]  txp;
    udps_ty_t    typ;
  } udps_cmd_t;
endpackage
`default_nettype wire

/* File: udps_sequencer.sv */
/*
  Packet sequencer: segment tables for four packets, sixteen commands,
  sixteen mapped data registers, byte-stream transmit and receive.
  Assumes tx/rx byte handshakes come from serial logic on ref_clk.
*/
// Summary of operation
// R01 - Packets hold up to 64 numbered segments
// R02 - Segments: message, address, length or checksum
// R03 - Duplicate address, length or checksum rejected
// R04 - Constants hex, ASCII or control code
// R05 - Hex format: ASCII to value, else 0; the code sends length and checksum bytes in hex format unconverted
// R06 - ASCII format: value to character, else 0
// R07 - Null format passes data unchanged
// R08 - Reverse swaps checksum high and low bytes
// R09 - Length field one or two bytes
// R10 - Checksum has initial value, class, format
// R11 - Variables read, write or ignore mapped registers
// R12 - Commands send, receive or send-then-receive
// R13 - Commands run in ascending number order
// R14 - Success: next, goto or end
// R15 - Failure: next, goto or abort
// R16 - Goto only to a higher command
// R17 - Failed command retried up to count
// R18 - Successful command repeated by count
// R19 - Millisecond wait between commands
// R20 - Millisecond reply timeout, zero disables
// R21 - Groups run one after another
// R22 - Receive mismatch fails the command
// R23 - Checksum covers bytes before checksum segment
`timescale 1ns/1ns
`default_nettype none
module udps_sequencer #(
  parameter int unsigned MS_CYCLES = udps_pkg::CYC_PER_MS
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [10:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             seq_busy
);
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_LAUNCH = 7'h02,
    ST_SEG    = 7'h04,
    ST_TBYTE  = 7'h08,
    ST_RBYTE  = 7'h10,
    ST_EVAL   = 7'h20,
    ST_GRPEND = 7'h40
  } udps_state_t;

  logic [31:0] seg_mem [0:255];
  logic [31:0] cmd_mem [0:15];
  logic [15:0] mreg    [0:15];

  logic [15:0] wait_ms;
  logic [15:0] tmo_ms;
  logic [19:0] groups;
  udps_state_t state;
  logic [1:0]  grp_idx;
  logic [3:0]  cmd_idx;
  logic        phase_rx;
  logic [5:0]  seg_idx;
  udps_pkg::udps_seg_t seg;
  logic        byte_k;
  logic        scan;
  logic [15:0] ck_sum;
  logic [7:0]  ck_xor;
  logic [2:0]  seen;
  logic        failed;
  logic [3:0]  try_cnt;
  logic [3:0]  rep_cnt;
  logic        first;
  logic        done;
  logic        aborted;
  logic        cfg_err;
  logic        tmo_flag;
  logic        tmr_clr;
  logic [15:0] tmr_cyc;
  logic [15:0] tmr_ms;

  // Hex digit character to value, else 0
  function automatic logic [7:0] to_hex(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return c - 8'h30;
    else if (c >= 8'h41 && c <= 8'h46) return c - 8'h37;
    else if (c >= 8'h61 && c <= 8'h66) return c - 8'h57;
    else return 8'h00;
  endfunction

  // Value 0..15 to hex digit character, else 0
  function automatic logic [7:0] to_asc(input logic [7:0] v);
    if (v <= 8'h09) return v + 8'h30;
    else if (v <= 8'h0f) return v + 8'h37;
    else return 8'h00;
  endfunction

  function automatic logic [7:0] conv(input udps_pkg::udps_fmt_t f, input logic [7:0] b);
    unique case (f)
      udps_pkg::FMT_HEX:   return to_hex(b);  // see R05
      udps_pkg::FMT_ASCII: return to_asc(b);  // see R06
      default:             return b;          // see R07
    endcase
  endfunction

  function automatic logic [3:0] grp_start(input logic [19:0] g, input logic [1:0] i);
    return g[4 + 4 * i +: 4];
  endfunction

  wire logic [3:0] next_cmd = cmd_idx + 4'h1;
  udps_pkg::udps_cmd_t cmd;
  udps_pkg::udps_seg_t ld;
  logic [1:0]  pkt;
  logic [15:0] ck_word;
  logic [15:0] w16;
  logic        nb2;
  logic        cvt;
  logic [7:0]  raw_byte;
  logic [7:0]  out_byte;
  logic        seg_end;
  logic        pkt_end;
  logic        tmo_hit;
  logic        wr_back;
  logic        ck_ok_cls;

  assign cmd = udps_pkg::udps_cmd_t'(cmd_mem[cmd_idx]);
  assign pkt = phase_rx ? cmd.rxp : cmd.txp;  // see R12
  assign ld  = udps_pkg::udps_seg_t'(seg_mem[{pkt, seg_idx}]);

  always_comb begin
    unique case (seg.ckcls)  // see R10
      udps_pkg::CK_XOR8: ck_word = {8'h00, ck_xor ^ seg.val};
      udps_pkg::CK_SUM8: ck_word = {8'h00, ck_sum[7:0] + seg.val};
      default:           ck_word = ck_sum + {8'h00, seg.val};
    endcase
    if (seg.rev) begin
      ck_word = {ck_word[7:0], ck_word[15:8]};  // see R08
    end
    if (seg.cls == udps_pkg::CLS_CKS) begin
      w16 = ck_word;
    end else if (seg.vsel) begin
      w16 = mreg[seg.val[3:0]];  // see R11
    end else begin
      w16 = {8'h00, seg.val};
    end
    // Constants go out as entered, control codes included
    cvt      = seg.vsel || seg.cls == udps_pkg::CLS_LEN || seg.cls == udps_pkg::CLS_CKS;  // see R04
    nb2      = seg.two && (cvt || seg.cls == udps_pkg::CLS_LEN);  // see R09
    raw_byte = (nb2 && !byte_k) ? w16[15:8] : w16[7:0];
    out_byte = cvt && !(seg.fmt == udps_pkg::FMT_HEX && seg.cls[1]) ? conv(seg.fmt, raw_byte)
               : raw_byte;  // see R05
    seg_end  = !nb2 || byte_k;
    pkt_end  = seg.last || seg_idx == udps_pkg::SEG_LAST;  // see R01
    tmo_hit  = tmo_ms != 16'h0000 && tmr_ms >= tmo_ms;  // see R20
    ck_ok_cls = seg.cls != udps_pkg::CLS_CKS;  // see R23
  end

  // Received byte into a mapped register
  assign wr_back = state == ST_RBYTE && rx_valid && seg.vsel && !tmo_hit
                   && seg.func == udps_pkg::FN_WRITE
                   && (seg.cls == udps_pkg::CLS_MSG || seg.cls == udps_pkg::CLS_ADDR);

  always_ff @(posedge ref_clk) begin
    if (reg_wr && reg_addr[10]) begin
      seg_mem[reg_addr[9:2]] <= reg_wdata;
    end
    if (reg_wr && reg_addr[10:6] == udps_pkg::SEL_CMD) begin
      cmd_mem[reg_addr[5:2]] <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_back) begin  // see R11
      if (nb2 && !byte_k) begin
        mreg[seg.val[3:0]][15:8] <= conv(seg.fmt, rx_data);
      end else begin
        mreg[seg.val[3:0]][7:0] <= conv(seg.fmt, rx_data);
      end
    end else if (reg_wr && reg_addr[10:6] == udps_pkg::SEL_MREG) begin
      mreg[reg_addr[5:2]] <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_ms <= udps_pkg::WAIT_RST;
      tmo_ms  <= udps_pkg::TMO_RST;
      groups  <= udps_pkg::GROUPS_RST;
    end else if (reg_wr) begin
      if (reg_addr == udps_pkg::OFS_WAIT) wait_ms <= reg_wdata[15:0];
      if (reg_addr == udps_pkg::OFS_TMO) tmo_ms <= reg_wdata[15:0];
      if (reg_addr == udps_pkg::OFS_GROUPS) groups <= reg_wdata[19:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      if (reg_addr[10]) begin
        reg_rdata <= seg_mem[reg_addr[9:2]];
      end else if (reg_addr[10:6] == udps_pkg::SEL_CMD) begin
        reg_rdata <= cmd_mem[reg_addr[5:2]];
      end else if (reg_addr[10:6] == udps_pkg::SEL_MREG) begin
        reg_rdata <= {16'h0000, mreg[reg_addr[5:2]]};
      end else if (reg_addr == udps_pkg::OFS_STATUS) begin
        reg_rdata <= {20'h00000, cmd_idx, 1'b0, grp_idx, tmo_flag,
                      cfg_err, aborted, done, seq_busy};
      end else if (reg_addr == udps_pkg::OFS_WAIT) begin
        reg_rdata <= {16'h0000, wait_ms};
      end else if (reg_addr == udps_pkg::OFS_TMO) begin
        reg_rdata <= {16'h0000, tmo_ms};
      end else if (reg_addr == udps_pkg::OFS_GROUPS) begin
        reg_rdata <= {12'h000, groups};
      end else begin
        reg_rdata <= 32'h0;
      end
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // Shared by wait and timeout phases
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tmr_cyc <= 16'h0000;
      tmr_ms  <= 16'h0000;
    end else if (tmr_clr) begin
      tmr_cyc <= 16'h0000;
      tmr_ms  <= 16'h0000;
    end else if (tmr_cyc == 16'(MS_CYCLES - 1)) begin
      tmr_cyc <= 16'h0000;
      if (tmr_ms != 16'hffff) tmr_ms <= tmr_ms + 16'h0001;
    end else begin
      tmr_cyc <= tmr_cyc + 16'h0001;
    end
  end

  wire logic start_req = reg_wr && reg_addr == udps_pkg::OFS_CTRL && reg_wdata[udps_pkg::CTRL_START];
  wire logic stop_req  = reg_wr && reg_addr == udps_pkg::OFS_CTRL && reg_wdata[udps_pkg::CTRL_STOP];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= ST_IDLE;
      grp_idx  <= 2'h0;
      cmd_idx  <= 4'h0;
      phase_rx <= 1'b0;
      seg_idx  <= 6'h00;
      seg      <= '0;
      byte_k   <= 1'b0;
      scan     <= 1'b0;
      ck_sum   <= 16'h0000;
      ck_xor   <= 8'h00;
      seen     <= 3'h0;
      failed   <= 1'b0;
      try_cnt  <= 4'h0;
      rep_cnt  <= 4'h0;
      first    <= 1'b0;
      done     <= 1'b0;
      aborted  <= 1'b0;
      cfg_err  <= 1'b0;
      tmo_flag <= 1'b0;
      tmr_clr  <= 1'b1;
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
      seq_busy <= 1'b0;
    end else begin
      tmr_clr <= 1'b0;
      if (stop_req && state != ST_IDLE) begin
        state    <= ST_IDLE;
        aborted  <= 1'b1;
        seq_busy <= 1'b0;
        tx_valid <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            if (start_req) begin
              grp_idx  <= 2'h0;
              cmd_idx  <= grp_start(groups, 2'h0);  // see R21
              first    <= 1'b1;
              try_cnt  <= 4'h0;
              rep_cnt  <= 4'h0;
              done     <= 1'b0;
              aborted  <= 1'b0;
              cfg_err  <= 1'b0;
              tmo_flag <= 1'b0;
              seq_busy <= 1'b1;
              tmr_clr  <= 1'b1;
              state    <= ST_LAUNCH;
            end
          end
          ST_LAUNCH: begin
            if (first || tmr_ms >= wait_ms) begin  // see R19
              first    <= 1'b0;
              phase_rx <= cmd.typ == udps_pkg::TY_RECV;
              seg_idx  <= 6'h00;
              ck_sum   <= 16'h0000;
              ck_xor   <= 8'h00;
              seen     <= 3'h0;
              scan     <= 1'b1;
              failed   <= cmd.typ == udps_pkg::TY_NONE;  // see R12
              tmr_clr  <= 1'b1;
              state    <= cmd.typ == udps_pkg::TY_NONE ? ST_EVAL : ST_SEG;
            end
          end
          ST_SEG: begin
            if (scan && ld.cls != udps_pkg::CLS_MSG && seen[ld.cls - 2'h1]) begin  // see R02
              cfg_err  <= 1'b1;  // see R03
              aborted  <= 1'b1;
              seq_busy <= 1'b0;
              state    <= ST_IDLE;
            end else begin
              if (ld.cls != udps_pkg::CLS_MSG) seen[ld.cls - 2'h1] <= 1'b1;
              seg    <= ld;
              byte_k <= 1'b0;
              if (!scan) begin
                state <= phase_rx ? ST_RBYTE : ST_TBYTE;
              end else begin
                seg_idx <= ld.last ? 6'h00 : seg_idx + 6'h01;
                scan    <= !ld.last && seg_idx != udps_pkg::SEG_LAST;  // see R03
              end
            end
          end
          ST_TBYTE: begin
            if (tmo_hit) begin
              failed   <= 1'b1;
              tmo_flag <= 1'b1;
              tx_valid <= 1'b0;
              state    <= ST_EVAL;
            end else if (!tx_valid) begin
              tx_data  <= out_byte;
              tx_valid <= 1'b1;
            end else if (tx_ready) begin
              tx_valid <= 1'b0;
              if (ck_ok_cls) begin  // see R23
                ck_sum <= ck_sum + {8'h00, tx_data};
                ck_xor <= ck_xor ^ tx_data;
              end
              byte_k <= 1'b1;
              if (seg_end && pkt_end) begin
                if (cmd.typ == udps_pkg::TY_BOTH) begin
                  phase_rx <= 1'b1;
                  scan     <= 1'b1;
                  seg_idx  <= 6'h00;
                  ck_sum   <= 16'h0000;
                  ck_xor   <= 8'h00;
                  seen     <= 3'h0;
                  state    <= ST_SEG;
                end else begin
                  state <= ST_EVAL;
                end
              end else if (seg_end) begin
                seg_idx <= seg_idx + 6'h01;
                state   <= ST_SEG;
              end
            end
          end
          ST_RBYTE: begin
            if (tmo_hit) begin
              failed   <= 1'b1;
              tmo_flag <= 1'b1;
              state    <= ST_EVAL;
            end else if (rx_valid) begin
              if (ck_ok_cls) begin  // see R23
                ck_sum <= ck_sum + {8'h00, rx_data};
                ck_xor <= ck_xor ^ rx_data;
              end
              byte_k <= 1'b1;
              // Constants, read variables and checksum must match
              if ((!seg.vsel || seg.func == udps_pkg::FN_READ
                   || seg.cls == udps_pkg::CLS_CKS) && rx_data != out_byte) begin
                failed <= 1'b1;  // see R22
                state  <= ST_EVAL;
              end else if (seg_end && pkt_end) begin
                state <= ST_EVAL;
              end else if (seg_end) begin
                seg_idx <= seg_idx + 6'h01;
                state   <= ST_SEG;
              end
            end
          end
          ST_EVAL: begin
            tmr_clr <= 1'b1;
            state   <= ST_LAUNCH;
            if (!failed && rep_cnt < cmd.repeat_n) begin
              rep_cnt <= rep_cnt + 4'h1;  // see R18
            end else if (failed && try_cnt < cmd.retry_n) begin
              try_cnt <= try_cnt + 4'h1;  // see R17
            end else begin
              rep_cnt <= 4'h0;
              try_cnt <= 4'h0;
              if (!failed) begin  // see R14
                if (cmd.sact == udps_pkg::ACT_NEXT && cmd_idx != udps_pkg::CMD_LAST) begin
                  cmd_idx <= next_cmd;  // see R13
                end else if (cmd.sact == udps_pkg::ACT_GOTO && cmd.stgt > cmd_idx) begin
                  cmd_idx <= cmd.stgt;  // see R16
                end else begin
                  state <= ST_GRPEND;
                end
              end else begin  // see R15
                if (cmd.fact == udps_pkg::ACT_NEXT && cmd_idx != udps_pkg::CMD_LAST) begin
                  cmd_idx <= next_cmd;  // see R13
                end else if (cmd.fact == udps_pkg::ACT_GOTO && cmd.ftgt > cmd_idx) begin
                  cmd_idx <= cmd.ftgt;  // see R16
                end else if (cmd.fact == udps_pkg::ACT_STOP) begin
                  aborted  <= 1'b1;
                  seq_busy <= 1'b0;
                  state    <= ST_IDLE;
                end else begin
                  state <= ST_GRPEND;
                end
              end
            end
          end
          ST_GRPEND: begin
            if (grp_idx < groups[1:0]) begin
              grp_idx <= grp_idx + 2'h1;  // see R21
              cmd_idx <= grp_start(groups, grp_idx + 2'h1);
              tmr_clr <= 1'b1;
              state   <= ST_LAUNCH;
            end else begin
              done     <= 1'b1;
              seq_busy <= 1'b0;
              state    <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: udps_sequencer_checker.sv */
/*
  Port assertions for the packet sequencer.
  Assumes ref_clk only, rst_b async active low.
*/
`timescale 1ns/1ns
`default_nettype none
module udps_sequencer_checker #(
  parameter int unsigned MS_CYCLES = 20000
) (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [10:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_valid,
  input wire logic        seq_busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence start_req;
    reg_wr && reg_addr == udps_pkg::OFS_CTRL && reg_wdata[0] && !reg_wdata[1] && !seq_busy;
  endsequence
  sequence stop_req;
    reg_wr && reg_addr == udps_pkg::OFS_CTRL && reg_wdata[1];
  endsequence
  sequence byte_wait;
    tx_valid && !tx_ready;
  endsequence
  sequence byte_taken;
    tx_valid && tx_ready;
  endsequence
  sequence wait_wr_rd;
    reg_wr && reg_addr == udps_pkg::OFS_WAIT ##2 reg_rd && reg_addr == udps_pkg::OFS_WAIT;
  endsequence

  tx_hold_a: assert property (byte_wait |=> !tx_valid || $stable(tx_data))
    else $error("tx byte moved");
  tx_gap_a: assert property (byte_taken |=> !tx_valid)
    else $error("no gap after byte");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("stray read data");
  ctrl_read_a: assert property (reg_rd && reg_addr == udps_pkg::OFS_CTRL |=> reg_rdata == 32'h0)
    else $error("ctrl read not zero");
  hole_read_a: assert property (reg_rd && reg_addr == 11'h014 |=> reg_rdata == 32'h0)
    else $error("hole read not zero");
  wait_back_a: assert property (wait_wr_rd |=> reg_rdata == {16'h0, $past(reg_wdata[15:0], 3)})
    else $error("wait readback");
  start_busy_a: assert property (start_req |-> ##[1:3] seq_busy)
    else $error("no busy on start");
  stop_idle_a: assert property (stop_req |-> ##[1:2] !seq_busy)
    else $error("busy after stop");
  idle_tx_a: assert property (!seq_busy [*2] |-> !tx_valid)
    else $error("tx while idle");
  tx_rise_a: assert property ($rose(tx_valid) |-> seq_busy)
    else $error("tx outside run");
endmodule

bind udps_sequencer udps_sequencer_checker #(.MS_CYCLES(MS_CYCLES)) udps_sequencer_checker_i (
  .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
  .seq_busy(seq_busy)
);
`default_nettype wire

/* File: udps_slave.sv */
/*
  Slave model on the byte link: logs bytes, plays replies.
  Assumes ref_clk; bench fills rq, negatives pause.
*/
`timescale 1ns/1ns
`default_nettype none
module udps_slave (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic      [7:0] rx_data,
  output logic            rx_valid
);
  int   got[$];
  int   at[$];
  int   rq[$];
  int   cyc;
  int   hold;
  int   v;
  logic stall = 1'b0;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      cyc <= 0;
      hold <= 0;
    end else begin
      cyc <= cyc + 1;
      // Slow mode: one byte per three cycles
      tx_ready <= !stall || (cyc % 3 == 0);
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
        at.push_back(cyc);
      end
      rx_valid <= 1'b0;
      // Toggling idle data exposes stale reads
      rx_data <= ~rx_data;
      if (hold > 0) begin
        hold <= hold - 1;
      end else if (rq.size() > 0) begin
        v = rq.pop_front();
        if (v < 0) begin
          hold <= -v;
        end else begin
          rx_valid <= 1'b1;
          rx_data <= 8'(v);
          hold <= 2;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: udps_sequencer_bench.sv */
/*
  Packet sequencer bench.
  Assumes the slave model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module udps_sequencer_bench;
  logic        ref_clk, rst_b, reg_wr, reg_rd, tx_valid, tx_ready, rx_valid, seq_busy;
  logic [10:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [7:0]  tx_data, rx_data;
  int          bad_count, n_compared, cyc, i, n;

  udps_sequencer #(.MS_CYCLES(20)) udps_sequencer_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .seq_busy(seq_busy));
  udps_slave udps_slave_i (.ref_clk(ref_clk), .rst_b(rst_b), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [10:0] a, logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [10:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function automatic udps_pkg::udps_seg_t sg(logic [7:0] v, logic l, logic [1:0] c, f,
      logic vs = '0, logic [1:0] fn = '0, logic tw = '0, rv = '0, logic [1:0] k = '0);
    return {12'h0, k, rv, tw, fn, vs, f, c, l, v};
  endfunction
  function automatic udps_pkg::udps_cmd_t cm(logic [1:0] ty, tx = '0, rx = '0, sa = '0,
      logic [3:0] st = '0, logic [1:0] fa = '0, logic [3:0] ft = '0, rt = '0, rp = '0);
    return {6'h0, rp, rt, ft, fa, st, sa, rx, tx, ty};
  endfunction
  task automatic seg(int p, int s, logic [31:0] w);
    wr(11'(1024 + 4 * (p * 64 + s)), w);
  endtask
  task automatic cmd(int c, logic [31:0] w);
    wr(11'(128 + 4 * c), w);
  endtask
  // Start and wait for idle
  task automatic run();
    udps_slave_i.got.delete();
    udps_slave_i.at.delete();
    wr(udps_pkg::OFS_CTRL, 32'h1);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while ((n < 3 || seq_busy !== 1'b0) && n < 5000);
    chk("busy_end", seq_busy, 0);
  endtask

  task automatic t_reset();
    logic [10:0] ra[5] = '{0, 4, 8, 'hc, 'h14};
    logic [31:0] re[5] = '{0, 0, 0, 'h32, 0};
    for (i = 0; i < 5; i++) begin
      rd(ra[i]);
      chk("reset_value", d, re[i]);
    end
  endtask

  task automatic t_frame();
    logic [7:0] e[9] = '{8'h02, 8'h42, 8'h07, 8'h00, 8'ha5, 8'h00, 8'h09, 8'h09, 8'h01};
    wr(11'h040, 32'h0b);
    wr(11'h044, 32'h37);
    wr(11'h048, 32'h5a);
    wr(11'h04c, 32'ha5);
    seg(0, 0, sg(8'h02, 0, 2'h0, 2'h3));
    seg(0, 1, sg(8'h00, 0, 2'h0, 2'h2, 1));
    seg(0, 2, sg(8'h01, 0, 2'h0, 2'h1, 1));
    seg(0, 3, sg(8'h02, 0, 2'h0, 2'h1, 1));
    seg(0, 4, sg(8'h03, 0, 2'h0, 2'h0, 1));
    seg(0, 5, sg(8'h09, 0, 2'h2, 2'h1, 0, 2'h0, 1));
    seg(0, 6, sg(8'h10, 1, 2'h3, 2'h0, 0, 2'h0, 1, 1));
    cmd(0, cm(2'h1, 0, 0, 2'h2, 0, 2'h2));
    udps_slave_i.stall = 1'b1;
    run();
    chk("tx_count", udps_slave_i.got.size(), 9);
    for (i = 0; i < 9; i++) begin
      chk("tx_byte", udps_slave_i.got[i], e[i]);
    end
    rd(udps_pkg::OFS_STATUS);
    chk("frame_done", d[2:1], 2'b01);
  endtask

  task automatic t_recv();
    int r[16] = '{-15, 'haa, 'h33, 0, -15, 'haa, 'h33, 0,
                  -15, 'haa, 'h5c, 'hf6, -15, 'haa, 'h5c, 'hf6};
    seg(1, 0, sg(8'haa, 0, 2'h0, 2'h1));
    seg(1, 1, sg(8'h04, 0, 2'h0, 2'h0, 1, 2'h1));
    seg(1, 2, sg(8'h00, 1, 2'h3, 2'h0, 0, 2'h0, 0, 0, 2'h1));
    seg(2, 0, sg(8'h11, 1, 2'h0, 2'h1));
    seg(3, 0, sg(8'h22, 1, 2'h0, 2'h1));
    cmd(0, cm(2'h2, 0, 1, 2'h0, 0, 2'h1, 3, 1));
    cmd(1, cm(2'h1, 2));
    cmd(2, cm(2'h1, 2));
    cmd(3, cm(2'h2, 0, 1, 2'h2, 0, 2'h2, 0, 0, 1));
    udps_slave_i.stall = 1'b0;
    foreach (r[j]) udps_slave_i.rq.push_back(r[j]);
    run();
    chk("skipped_cmds", udps_slave_i.got.size(), 0);
    chk("replies_used", udps_slave_i.rq.size(), 0);
    rd(udps_pkg::OFS_STATUS);
    chk("recv_done", d[2:1], 2'b01);
    rd(11'h050);
    chk("mapped_write", d, 32'h5c);
  endtask

  task automatic t_tmo();
    wr(udps_pkg::OFS_TMO, 32'h2);
    cmd(0, cm(2'h2, 0, 1, 2'h2, 0, 2'h2));
    run();
    chk("tmo_cycles", n >= 40 && n <= 52, 1);
    rd(udps_pkg::OFS_STATUS);
    chk("tmo_flags", {d[4], d[2]}, 2'b11);
    wr(udps_pkg::OFS_TMO, 32'h0);
    wr(udps_pkg::OFS_CTRL, 32'h1);
    repeat (300) @(negedge ref_clk);
    chk("no_tmo_busy", seq_busy, 1);
    wr(udps_pkg::OFS_CTRL, 32'h2);
    repeat (2) @(negedge ref_clk);
    chk("stop_busy", seq_busy, 0);
    rd(udps_pkg::OFS_STATUS);
    chk("stop_flags", {d[4], d[2]}, 2'b01);
  endtask

  task automatic t_groups();
    wr(udps_pkg::OFS_WAIT, 32'h1);
    rd(udps_pkg::OFS_WAIT);
    chk("wait_reg", d, 32'h1);
    cmd(5, cm(2'h1, 2, 0, 2'h0, 0, 2'h2));
    cmd(6, cm(2'h1, 3, 0, 2'h2, 0, 2'h2));
    cmd(7, cm(2'h1, 2, 0, 2'h2, 0, 2'h2));
    wr(udps_pkg::OFS_GROUPS, 32'h751);
    run();
    chk("group_count", udps_slave_i.got.size(), 3);
    chk("group_bytes", {8'(udps_slave_i.got[0]), 8'(udps_slave_i.got[1]),
                        8'(udps_slave_i.got[2])}, 24'h112211);
    chk("wait_gap", udps_slave_i.at[1] - udps_slave_i.at[0] >= 20, 1);
  endtask

  task automatic t_cfg();
    seg(3, 0, sg(8'h00, 0, 2'h3, 2'h0));
    seg(3, 1, sg(8'h00, 1, 2'h3, 2'h0));
    cmd(0, cm(2'h1, 3, 0, 2'h2, 0, 2'h2));
    wr(udps_pkg::OFS_GROUPS, 32'h0);
    wr(udps_pkg::OFS_WAIT, 32'h0);
    run();
    chk("cfg_sent", udps_slave_i.got.size(), 0);
    rd(udps_pkg::OFS_STATUS);
    chk("cfg_flag", d[3], 1);
  endtask

  task automatic summarize();
    $display("mismatches %0d of %0d compares", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Run needs under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc >= 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 11'h000;
    reg_wdata = 32'h0;
    bad_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_frame();
    t_recv();
    t_tmo();
    t_groups();
    t_cfg();
    summarize();
  end
endmodule
`default_nettype wire
